// file: rtl/udq_desc_image.sv
`timescale 1ns/1ps

// What this block does
// - Endpoint descriptors report fixed length 07h, type 05h.
// - Endpoint two: address 02h, bulk, interval 00h.
// - Bulk-out max packet 512 at high speed.
// - Bulk interval always zero; host ignores it.
// - Endpoint three: address 83h, interrupt, packet 10h.
// - Of the endpoint bytes, only endpoint three interval comes from memory.
// - Without memory, interrupt interval is 04h.
// - Other-speed config: length 09h, type 07h.
// - Other-speed total length reports 0027h.
// - One interface, value 01h, string index overridable.
// - Other-speed attributes default A0h when bus powered with the strap set (E0h self powered), memory overridable.
// - Remote wake strap shapes attributes default.
// - Max power 01h self, FAh bus, overridable.
// - Other-speed uses the opposite speed's stored set.
// - Qualifier reports length 0Ah, type 06h, fixed.
// - Qualifier: release 0200h, packet 40h, one config, zero.
// - Qualifier class bytes default FFh, 00h, FFh.
// - Qualifier memory values use the opposite speed.
module udq_desc_image
    import udq_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Configuration memory loader.
    input wire logic cfg_present_i,
    input wire logic cfg_we_i,
    input wire logic [4:0] cfg_addr_i,
    input wire logic [7:0] cfg_data_i,
    // Straps and operating status.
    input wire logic remote_wake_strap_i,
    input wire logic self_powered_i,
    input wire logic high_speed_i,
    // Descriptor request.
    input wire logic req_valid_i,
    input wire logic [1:0] req_sel_i,
    input wire logic [15:0] req_len_i,
    output logic req_ready_o,
    // Descriptor byte stream.
    output logic byte_valid_o,
    output logic [7:0] byte_data_o,
    output logic byte_last_o,
    input wire logic byte_ready_i,
    // End of transfer.
    output logic done_o
);

    // Sequencer state and byte position.
    udq_state_t state_q, state_d;
    udq_sel_t sel_q;
    logic [3:0] idx_q;
    logic [3:0] cnt_q;

    // Operating status frozen when a request is taken.
    logic hs_q;
    logic sp_q;
    logic present_q;

    // Strap capture after reset.
    logic strap_q;
    logic strap_taken_q;

    // Registers behind the outputs.
    logic req_ready_q;
    logic byte_valid_q;
    logic [7:0] byte_data_q;
    logic byte_last_q;
    logic done_q;

    // Returns {from_memory, memory address, fixed or default value}.
    // The address sum wraps in five bits; the image has 32 entries.
    function automatic logic [13:0] udq_mem(input logic [4:0] base, input logic [4:0] off,
                                            input logic [7:0] dflt);
        logic [4:0] a;
        a = 5'(base + off);
        udq_mem = {1'b1, a, dflt};
    endfunction : udq_mem

    // Byte selection for every descriptor, by offset.
    // Offsets past the end land in the default items and are never sent.
    function automatic logic [13:0] udq_pick(input udq_sel_t sel, input logic [3:0] idx,
                                             input logic hs, input logic [4:0] base,
                                             input logic [7:0] attr, input logic [7:0] pwr);
        logic [13:0] r;
        logic [15:0] mps;

        r = 14'h0000;
        mps = hs ? UDQ_EP2_MPS_HS : UDQ_EP2_MPS_FS;
        case (sel)
            // Bulk-out endpoint: every byte is hard-wired.
            UDQ_SEL_EP2: begin
                case (idx)
                    4'h0: r[7:0] = UDQ_EP_LEN;
                    4'h1: r[7:0] = UDQ_EP_TYPE;
                    4'h2: r[7:0] = UDQ_EP2_ADDR;
                    4'h3: r[7:0] = UDQ_EP2_ATTR;
                    4'h4: r[7:0] = mps[7:0];
                    4'h5: r[7:0] = mps[15:8];
                    default: r[7:0] = UDQ_EP2_INTERVAL;
                endcase
            end

            // Interrupt endpoint: only the polling interval may come from memory.
            UDQ_SEL_EP3: begin
                case (idx)
                    4'h0: r[7:0] = UDQ_EP_LEN;
                    4'h1: r[7:0] = UDQ_EP_TYPE;
                    4'h2: r[7:0] = UDQ_EP3_ADDR;
                    4'h3: r[7:0] = UDQ_EP3_ATTR;
                    4'h4: r[7:0] = UDQ_EP3_MPS[7:0];
                    4'h5: r[7:0] = UDQ_EP3_MPS[15:8];
                    default: r = {1'b1, UDQ_MEM_EP3_INT, UDQ_EP3_INT_DEF};
                endcase
            end

            // Other-speed configuration: length and type stay fixed.
            UDQ_SEL_OSC: begin
                case (idx)
                    4'h0: r[7:0] = UDQ_OSC_LEN;
                    4'h1: r[7:0] = UDQ_OSC_TYPE;
                    4'h2: r = udq_mem(base, UDQ_SO_TOTLO, UDQ_OSC_TOTLEN[7:0]);
                    4'h3: r = udq_mem(base, UDQ_SO_TOTHI, UDQ_OSC_TOTLEN[15:8]);
                    4'h4: r = udq_mem(base, UDQ_SO_NUMIF, UDQ_OSC_NUMIF);
                    4'h5: r = udq_mem(base, UDQ_SO_CFGVAL, UDQ_OSC_CFGVAL);
                    4'h6: r = udq_mem(base, UDQ_SO_ICFG, UDQ_OSC_ICFG);
                    4'h7: r = udq_mem(base, UDQ_SO_ATTR, attr);
                    default: r = udq_mem(base, UDQ_SO_PWR, pwr);
                endcase
            end

            // Device qualifier: length, type and the reserved byte stay fixed.
            default: begin
                case (idx)
                    4'h0: r[7:0] = UDQ_QUAL_LEN;
                    4'h1: r[7:0] = UDQ_QUAL_TYPE;
                    4'h2: r = udq_mem(base, UDQ_SO_BCDLO, UDQ_QUAL_BCD[7:0]);
                    4'h3: r = udq_mem(base, UDQ_SO_BCDHI, UDQ_QUAL_BCD[15:8]);
                    4'h4: r = udq_mem(base, UDQ_SO_CLASS, UDQ_QUAL_CLASS);
                    4'h5: r = udq_mem(base, UDQ_SO_SUBCL, UDQ_QUAL_SUBCL);
                    4'h6: r = udq_mem(base, UDQ_SO_PROTO, UDQ_QUAL_PROTO);
                    4'h7: r = udq_mem(base, UDQ_SO_MPS0, UDQ_QUAL_MPS0);
                    4'h8: r = udq_mem(base, UDQ_SO_NUMCFG, UDQ_QUAL_NUMCFG);
                    default: r[7:0] = UDQ_QUAL_RSVD;
                endcase
            end
        endcase
        udq_pick = r;
    endfunction : udq_pick

    // Request decode: descriptor size and the length actually sent.
    wire udq_sel_t req_sel = udq_sel_t'(req_sel_i);
    wire logic req_take = req_valid_i && req_ready_q;
    wire logic [3:0] desc_len = (req_sel == UDQ_SEL_OSC) ? UDQ_OSC_LEN_N :
                                (req_sel == UDQ_SEL_QUAL) ? UDQ_QUAL_LEN_N : UDQ_EP_LEN_N;
    wire logic req_short = req_len_i < {12'h000, desc_len};
    wire logic [3:0] send_len = req_short ? req_len_i[3:0] : desc_len;

    // The byte in hand is the final one of this transfer.
    wire logic last_byte = (idx_q == 4'(cnt_q - 4'h1));

    // Defaults that depend on the strap and the power mode.
    // Bus powered with the strap set gives A0h; self powered adds bit 6.
    wire logic [7:0] attr_wake = strap_q ? UDQ_OSC_ATTR_WK : 8'h00;
    wire logic [7:0] attr_self = sp_q ? UDQ_OSC_ATTR_SP : 8'h00;
    wire logic [7:0] attr_def = UDQ_OSC_ATTR_BAS | attr_wake | attr_self;
    wire logic [7:0] pwr_def = sp_q ? UDQ_OSC_PWR_SELF : UDQ_OSC_PWR_BUS;

    // The stored set for the other speed feeds both speed-dependent descriptors.
    // Running high speed reads the full speed set, and the other way round.
    wire logic [4:0] set_base = hs_q ? UDQ_MEM_FS_BASE : UDQ_MEM_HS_BASE;

    // Current byte selection and the memory answer it needs.
    // Without memory present every byte falls back to its default.
    wire logic [13:0] pick = udq_pick(sel_q, idx_q, hs_q, set_base, attr_def, pwr_def);
    wire logic pick_mem = pick[13];
    wire logic [4:0] pick_addr = pick[12:8];
    wire logic [7:0] pick_fixed = pick[7:0];
    wire logic [7:0] mem_rdata;
    wire logic [7:0] byte_next = (pick_mem && present_q) ? mem_rdata : pick_fixed;

    // The memory read address follows the selection; data are valid one cycle later.
    // Fixed bytes also drive a read address, but that answer is ignored.
    udq_cfg_mem u_mem (
        .mclk_i (mclk_i),
        .resetn_i (resetn_i),
        .we_i (cfg_we_i),
        .waddr_i (cfg_addr_i),
        .wdata_i (cfg_data_i),
        .raddr_i (pick_addr),
        .rdata_o (mem_rdata)
    );

    // Strap is caught once, on the first edge after reset is released.
    // Later strap changes have no effect until the next reset.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_q <= remote_wake_strap_i;
            strap_taken_q <= 1'b1;
        end
    end

    // Sequencer next state; each byte costs a read, a wait and a send.
    always_comb begin
        state_d = state_q;
        case (state_q)
            // An empty request is finished without leaving idle.
            UDQ_ST_IDLE: begin
                if (req_take && (send_len != 4'h0)) begin
                    state_d = UDQ_ST_RD;
                end
            end

            // The memory answers one cycle after its read address.
            UDQ_ST_RD: state_d = UDQ_ST_WT;
            UDQ_ST_WT: state_d = UDQ_ST_SEND;

            // The byte stays on offer until the consumer takes it.
            UDQ_ST_SEND: begin
                if (byte_ready_i) begin
                    state_d = last_byte ? UDQ_ST_IDLE : UDQ_ST_RD;
                end
            end
            default: state_d = UDQ_ST_IDLE;
        endcase
    end

    // Request context is held for the whole transfer so live status cannot tear it.
    // Power mode and memory presence are frozen together with the speed.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_q <= UDQ_SEL_EP2;
            cnt_q <= 4'h0;
            hs_q <= 1'b0;
            sp_q <= 1'b0;
            present_q <= 1'b0;
        end else if (req_take) begin
            sel_q <= req_sel;
            cnt_q <= send_len;
            hs_q <= high_speed_i;
            sp_q <= self_powered_i;
            present_q <= cfg_present_i;
        end
    end

    // State, byte index and the ready flag.
    // Ready comes from the next state, so it falls on the take edge itself.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= UDQ_ST_IDLE;
            idx_q <= 4'h0;
            req_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_ready_q <= (state_d == UDQ_ST_IDLE);
            if (req_take) begin
                idx_q <= 4'h0;
            end else if ((state_q == UDQ_ST_SEND) && byte_ready_i) begin
                idx_q <= 4'(idx_q + 4'h1);
            end
        end
    end

    // Output byte stays stable until the consumer takes it.
    // Only valid and last fall when a byte is taken; the data are left as they were.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            byte_valid_q <= 1'b0;
            byte_data_q <= 8'h00;
            byte_last_q <= 1'b0;
        end else if (state_q == UDQ_ST_WT) begin
            byte_valid_q <= 1'b1;
            byte_data_q <= byte_next;
            byte_last_q <= last_byte;
        end else if ((state_q == UDQ_ST_SEND) && byte_ready_i) begin
            byte_valid_q <= 1'b0;
            byte_last_q <= 1'b0;
        end
    end

    // Done pulses after the last byte, or at once for a zero-length request.
    // An empty request never leaves idle, so its end is flagged here.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (req_take && (send_len == 4'h0)) ||
                      ((state_q == UDQ_ST_SEND) && byte_ready_i && last_byte);
        end
    end

    // Every output comes straight from its flip-flop.
    assign req_ready_o = req_ready_q;
    assign byte_valid_o = byte_valid_q;
    assign byte_data_o = byte_data_q;
    assign byte_last_o = byte_last_q;
    assign done_o = done_q;

endmodule : udq_desc_image

// file: rtl/udq_pkg.sv
package udq_pkg;

    // Which descriptor a request asks for.
    typedef enum logic [1:0] {
        UDQ_SEL_EP2  = 2'b00,
        UDQ_SEL_EP3  = 2'b01,
        UDQ_SEL_OSC  = 2'b10,
        UDQ_SEL_QUAL = 2'b11
    } udq_sel_t;

    // Byte sequencer states.
    typedef enum logic [1:0] {
        UDQ_ST_IDLE = 2'b00,
        UDQ_ST_RD   = 2'b01,
        UDQ_ST_WT   = 2'b10,
        UDQ_ST_SEND = 2'b11
    } udq_state_t;

    // Descriptor lengths in bytes.
    localparam logic [3:0] UDQ_EP_LEN_N   = 4'h7;
    localparam logic [3:0] UDQ_OSC_LEN_N  = 4'h9;
    localparam logic [3:0] UDQ_QUAL_LEN_N = 4'hA;

    // Endpoint descriptor bytes.
    localparam logic [7:0] UDQ_EP_LEN       = 8'h07;
    localparam logic [7:0] UDQ_EP_TYPE      = 8'h05;
    localparam logic [7:0] UDQ_EP2_ADDR     = 8'h02;
    localparam logic [7:0] UDQ_EP2_ATTR     = 8'h02;
    localparam logic [7:0] UDQ_EP2_INTERVAL = 8'h00;
    localparam logic [15:0] UDQ_EP2_MPS_HS  = 16'h0200;
    localparam logic [15:0] UDQ_EP2_MPS_FS  = 16'h0040;
    localparam logic [7:0] UDQ_EP3_ADDR     = 8'h83;
    localparam logic [7:0] UDQ_EP3_ATTR     = 8'h03;
    localparam logic [15:0] UDQ_EP3_MPS     = 16'h0010;
    localparam logic [7:0] UDQ_EP3_INT_DEF  = 8'h04;

    // Other-speed configuration descriptor bytes.
    localparam logic [7:0] UDQ_OSC_LEN      = 8'h09;
    localparam logic [7:0] UDQ_OSC_TYPE     = 8'h07;
    localparam logic [15:0] UDQ_OSC_TOTLEN  = 16'h0027;
    localparam logic [7:0] UDQ_OSC_NUMIF    = 8'h01;
    localparam logic [7:0] UDQ_OSC_CFGVAL   = 8'h01;
    localparam logic [7:0] UDQ_OSC_ICFG     = 8'h00;
    localparam logic [7:0] UDQ_OSC_ATTR_BAS = 8'h80;
    localparam logic [7:0] UDQ_OSC_ATTR_WK  = 8'h20;
    localparam logic [7:0] UDQ_OSC_ATTR_SP  = 8'h40;
    localparam logic [7:0] UDQ_OSC_PWR_SELF = 8'h01;
    localparam logic [7:0] UDQ_OSC_PWR_BUS  = 8'hFA;

    // Device qualifier descriptor bytes.
    localparam logic [7:0] UDQ_QUAL_LEN     = 8'h0A;
    localparam logic [7:0] UDQ_QUAL_TYPE    = 8'h06;
    localparam logic [15:0] UDQ_QUAL_BCD    = 16'h0200;
    localparam logic [7:0] UDQ_QUAL_CLASS   = 8'hFF;
    localparam logic [7:0] UDQ_QUAL_SUBCL   = 8'h00;
    localparam logic [7:0] UDQ_QUAL_PROTO   = 8'hFF;
    localparam logic [7:0] UDQ_QUAL_MPS0    = 8'h40;
    localparam logic [7:0] UDQ_QUAL_NUMCFG  = 8'h01;
    localparam logic [7:0] UDQ_QUAL_RSVD    = 8'h00;

    // Configuration memory image: one interval byte, then a full and a high speed set.
    localparam int UDQ_MEM_AW = 5;
    localparam logic [4:0] UDQ_MEM_EP3_INT = 5'h00;
    localparam logic [4:0] UDQ_MEM_FS_BASE = 5'h01;
    localparam logic [4:0] UDQ_MEM_HS_BASE = 5'h0F;

    // Offsets within one speed set.
    localparam logic [4:0] UDQ_SO_TOTLO  = 5'h00;
    localparam logic [4:0] UDQ_SO_TOTHI  = 5'h01;
    localparam logic [4:0] UDQ_SO_NUMIF  = 5'h02;
    localparam logic [4:0] UDQ_SO_CFGVAL = 5'h03;
    localparam logic [4:0] UDQ_SO_ICFG   = 5'h04;
    localparam logic [4:0] UDQ_SO_ATTR   = 5'h05;
    localparam logic [4:0] UDQ_SO_PWR    = 5'h06;
    localparam logic [4:0] UDQ_SO_CLASS  = 5'h07;
    localparam logic [4:0] UDQ_SO_SUBCL  = 5'h08;
    localparam logic [4:0] UDQ_SO_PROTO  = 5'h09;
    localparam logic [4:0] UDQ_SO_BCDLO  = 5'h0A;
    localparam logic [4:0] UDQ_SO_BCDHI  = 5'h0B;
    localparam logic [4:0] UDQ_SO_MPS0   = 5'h0C;
    localparam logic [4:0] UDQ_SO_NUMCFG = 5'h0D;

endpackage : udq_pkg

// file: rtl/udq_cfg_mem.sv
`timescale 1ns/1ps

// Small image of the descriptor bytes copied in from configuration memory.
module udq_cfg_mem
    import udq_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Write port from the loader.
    input wire logic we_i,
    input wire logic [4:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Registered read port.
    input wire logic [4:0] raddr_i,
    output logic [7:0] rdata_o
);

    localparam int UDQ_DEPTH = 1 << UDQ_MEM_AW;

    logic [7:0] mem_q [UDQ_DEPTH];
    logic [7:0] rdata_q;

    // The array carries no reset so it maps onto plain storage.
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Read data come from a register, one cycle after the address.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule : udq_cfg_mem

// file: verif/udq_desc_image_assertions.sv
`timescale 1ns/1ps

// Watches the request and byte stream handshakes of the descriptor image.
module udq_desc_image_chk (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Request side.
    input wire logic req_valid_i,
    input wire logic [1:0] req_sel_i,
    input wire logic [15:0] req_len_i,
    input wire logic req_ready_o,
    // Byte stream side.
    input wire logic byte_valid_o,
    input wire logic [7:0] byte_data_o,
    input wire logic byte_last_o,
    input wire logic byte_ready_i,
    input wire logic done_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // Handshake events shared by the properties.
    wire logic take_w = req_valid_i && req_ready_o;
    wire logic moved_w = byte_valid_o && byte_ready_i;
    logic [7:0] first_q;
    logic [15:0] len_q;
    logic [4:0] cnt_q;

    // Remember the leading length byte and the requested count, then count sent bytes.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_q <= 8'h00;
            len_q <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (take_w) begin
            first_q <= (req_sel_i == 2'b10) ? 8'h09 : (req_sel_i == 2'b11) ? 8'h0A : 8'h07;
            len_q <= req_len_i;
            cnt_q <= 5'h00;
        end else if (moved_w) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // A byte is withdrawn and the next one follows within a few cycles.
    sequence s_gap;
        !byte_valid_o ##[1:3] byte_valid_o;
    endsequence
    // The end of a transfer: pulse, idle again, nothing offered.
    sequence s_finish;
        done_o && req_ready_o && !byte_valid_o;
    endsequence

    property p_first_byte;
        take_w && req_len_i != 16'h0000 |-> ##[1:4] (byte_valid_o && byte_data_o == first_q);
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("first byte is not the descriptor length");
    property p_ready_drop;
        take_w && req_len_i != 16'h0000 |=> !req_ready_o;
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready stayed high after a request was taken");
    property p_hold;
        byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o) && $stable(byte_last_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed before it was taken");
    property p_gap;
        moved_w && !byte_last_o |=> s_gap;
    endproperty
    a_gap: assert property (p_gap)
        else $error("next byte did not follow");
    property p_last_done;
        moved_w && byte_last_o |=> s_finish;
    endproperty
    a_last_done: assert property (p_last_done)
        else $error("transfer did not end after the last byte");
    property p_done_pulse;
        done_o |=> !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done lasted more than one cycle");
    property p_zero_len;
        take_w && req_len_i == 16'h0000 |-> ##[1:3] s_finish;
    endproperty
    a_zero_len: assert property (p_zero_len)
        else $error("empty request did not finish at once");
    property p_idle_quiet;
        req_ready_o |-> !byte_valid_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("byte offered while idle");
    property p_count;
        moved_w |-> ({11'h000, cnt_q} < len_q) && (cnt_q < 5'h0A);
    endproperty
    a_count: assert property (p_count)
        else $error("more bytes sent than requested or held");
endmodule : udq_desc_image_chk

bind udq_desc_image udq_desc_image_chk udq_desc_image_chk_i (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .req_valid_i(req_valid_i),
    .req_sel_i(req_sel_i),
    .req_len_i(req_len_i),
    .req_ready_o(req_ready_o),
    .byte_valid_o(byte_valid_o),
    .byte_data_o(byte_data_o),
    .byte_last_o(byte_last_o),
    .byte_ready_i(byte_ready_i),
    .done_o(done_o)
);

// file: verif/udq_host_model.sv
`timescale 1ns/1ps

// Control pipe consumer that collects descriptor bytes, promptly or slowly.
module udq_host_model (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Pacing control from the bench.
    input wire logic slow_i,
    // Byte stream.
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic last_i,
    output logic ready_o
);
    logic [7:0] got[$];
    int last_n = 0;

    // Slow mode refuses every other cycle, so the block has to hold its byte.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= slow_i ? ~ready_o : 1'b1;
        end
    end

    // Bytes are kept in arrival order; the interval field is stored but never acted on.
    always @(posedge mclk_i) begin
        if (resetn_i && valid_i && ready_o) begin
            got.push_back(data_i);
            if (last_i) last_n = got.size();
        end
    end
endmodule : udq_host_model

// file: verif/test_usb_descriptor_image_ep_qualifier.sv
`timescale 1ns/1ps

// Self-checking bench for the descriptor image, one task per scenario.
module test_usb_descriptor_image_ep_qualifier;
    import udq_pkg::*;

    // Design inputs and outputs.
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cfg_present_i = 1'b0;
    logic cfg_we_i = 1'b0;
    logic [4:0] cfg_addr_i = 5'h00;
    logic [7:0] cfg_data_i = 8'h00;
    logic remote_wake_strap_i = 1'b1;
    logic self_powered_i = 1'b0;
    logic high_speed_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [1:0] req_sel_i = 2'b00;
    logic [15:0] req_len_i = 16'h0000;
    logic req_ready_o, byte_valid_o, byte_last_o, byte_ready_i, done_o, slow = 1'b0;
    logic [7:0] byte_data_o;
    logic [7:0] ex[$];
    int fails = 0;
    int n_compared = 0;

    always #4 mclk_i = ~mclk_i;

    udq_desc_image udq_desc_image_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .cfg_present_i(cfg_present_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i),
        .cfg_data_i(cfg_data_i), .remote_wake_strap_i(remote_wake_strap_i),
        .self_powered_i(self_powered_i), .high_speed_i(high_speed_i),
        .req_valid_i(req_valid_i), .req_sel_i(req_sel_i), .req_len_i(req_len_i),
        .req_ready_o(req_ready_o), .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
        .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i), .done_o(done_o));
    udq_host_model udq_host_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(slow),
        .valid_i(byte_valid_o), .data_i(byte_data_o), .last_i(byte_last_o),
        .ready_o(byte_ready_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // The strap is caught just after release, so it is set while reset is held.
    task automatic do_reset(input logic strap);
        remote_wake_strap_i <= strap;
        resetn_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask : do_reset

    // Write enable stays high across a burst so no edge sees it toggled twice.
    task automatic load(input logic [4:0] base, input logic [7:0] img[$]);
        foreach (img[k]) begin
            cfg_we_i <= 1'b1;
            cfg_addr_i <= base + 5'(k);
            cfg_data_i <= img[k];
            @(posedge mclk_i);
        end
        cfg_we_i <= 1'b0;
    endtask : load

    // Mode packs speed, memory present and self powered; expected bytes sit in ex.
    task automatic run(input logic [1:0] sel, input logic [15:0] len, input logic [2:0] mode);
        int n;
        n = (len < ex.size()) ? len : ex.size();
        udq_host_model_i.got.delete();
        udq_host_model_i.last_n = 0;
        {high_speed_i, cfg_present_i, self_powered_i} <= mode;
        req_valid_i <= 1'b1;
        req_sel_i <= sel;
        req_len_i <= len;
        repeat (50) begin
            @(posedge mclk_i);
            if (req_ready_o === 1'b1) break;
        end
        check(16'(req_ready_o), 16'h0001);
        req_valid_i <= 1'b0;
        repeat (200) begin
            @(posedge mclk_i);
            if (done_o === 1'b1) break;
        end
        check(16'(done_o), 16'h0001);
        check(16'(udq_host_model_i.got.size()), 16'(n));
        foreach (udq_host_model_i.got[k]) check(udq_host_model_i.got[k], ex[k]);
        check(16'(udq_host_model_i.last_n), 16'(n));
    endtask : run

    task automatic t_endpoints();
        ex = '{8'h07, 8'h05, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00};
        run(UDQ_SEL_EP2, 16'h0007, 3'b110);
        ex[4] = 8'h40;
        ex[5] = 8'h00;
        run(UDQ_SEL_EP2, 16'h0040, 3'b000);
        ex = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, 8'h04};
        run(UDQ_SEL_EP3, 16'h0007, 3'b100);
        load(UDQ_MEM_EP3_INT, '{8'h0B});
        ex[6] = 8'h0B;
        run(UDQ_SEL_EP3, 16'h00FF, 3'b010);
    endtask : t_endpoints

    task automatic t_osc_defaults();
        ex = '{8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0, 8'hFA};
        run(UDQ_SEL_OSC, 16'h0009, 3'b100);
        ex[7] = 8'hE0;
        ex[8] = 8'h01;
        run(UDQ_SEL_OSC, 16'h00FF, 3'b001);
    endtask : t_osc_defaults

    task automatic t_qual_slow();
        slow <= 1'b1;
        ex = '{8'h0A, 8'h06, 8'h00, 8'h02, 8'hFF, 8'h00, 8'hFF, 8'h40, 8'h01, 8'h00};
        run(UDQ_SEL_QUAL, 16'h0012, 3'b000);
        slow <= 1'b0;
    endtask : t_qual_slow

    // Each speed set gets its own string index, power and class bytes to tell them apart.
    task automatic t_image();
        load(UDQ_MEM_FS_BASE, '{8'h27, 8'h00, 8'h01, 8'h01, 8'h05, 8'hC0, 8'h32,
            8'h11, 8'h22, 8'h33, 8'h00, 8'h02, 8'h40, 8'h01});
        load(UDQ_MEM_HS_BASE, '{8'h27, 8'h00, 8'h01, 8'h01, 8'h06, 8'hA0, 8'h64,
            8'h44, 8'h55, 8'h66, 8'h00, 8'h02, 8'h40, 8'h01});
        ex = '{8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h05, 8'hC0, 8'h32};
        run(UDQ_SEL_OSC, 16'h0009, 3'b110);
        ex[6] = 8'h06;
        ex[7] = 8'hA0;
        ex[8] = 8'h64;
        run(UDQ_SEL_OSC, 16'h0009, 3'b011);
        ex = '{8'h0A, 8'h06, 8'h00, 8'h02, 8'h11, 8'h22, 8'h33, 8'h40, 8'h01, 8'h00};
        run(UDQ_SEL_QUAL, 16'h000A, 3'b110);
        ex[4] = 8'h44;
        ex[5] = 8'h55;
        ex[6] = 8'h66;
        run(UDQ_SEL_QUAL, 16'h000A, 3'b011);
    endtask : t_image

    // Short and empty requests back to back.
    task automatic t_trunc();
        ex = '{8'h07, 8'h05, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00};
        run(UDQ_SEL_EP2, 16'h0003, 3'b100);
        run(UDQ_SEL_EP2, 16'h0000, 3'b100);
        run(UDQ_SEL_EP2, 16'h0001, 3'b100);
    endtask : t_trunc

    // A second reset with the strap low drops the wake bit from the default.
    task automatic t_strap();
        do_reset(1'b0);
        ex = '{8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'hFA};
        run(UDQ_SEL_OSC, 16'h0009, 3'b000);
    endtask : t_strap

    // Main sequence.
    initial begin
        do_reset(1'b1);
        t_endpoints();
        t_osc_defaults();
        t_qual_slow();
        t_image();
        t_trunc();
        t_strap();
        tally_and_finish();
    end

    // The scenarios need well under two thousand cycles; this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        tally_and_finish();
    end
endmodule : test_usb_descriptor_image_ep_qualifier
